// [core/uaia_defines.vh]
// Constants for the USB audio interrupt aggregator
`ifndef UAIA_DEFINES_VH
`define UAIA_DEFINES_VH
// Register indexes (word address on the plain register port)
`define UAIA_A_USB_STATUS 4'h0
`define UAIA_A_USB_CONTROL 4'h1
`define UAIA_A_VECTOR 4'h2
`define UAIA_A_EP_IN_STAT 4'h3
`define UAIA_A_EP_OUT_STAT 4'h4
`define UAIA_A_EP_IN_MASK 4'h5
`define UAIA_A_EP_OUT_MASK 4'h6
`define UAIA_A_USB_MASK 4'h7
`define UAIA_A_CODEC_CTRL 4'h8
`define UAIA_A_CODEC_ADDR 4'h9
`define UAIA_A_CODEC_DATL 4'ha
`define UAIA_A_CODEC_DATH 4'hb
`define UAIA_A_MISC_MASK 4'hc
`define UAIA_A_PENDING 4'hd
// Status register bit positions
`define UAIA_B_RST 0
`define UAIA_B_SUS 1
`define UAIA_B_RES 2
`define UAIA_B_SOF 3
`define UAIA_B_PSEUDO_FRAME_FLAG 4
`define UAIA_B_SETUP 5
`define UAIA_B_SETUP_OVERWRITE_FLAG 6
// Control register bits
`define UAIA_B_FRST_EN 0
`define UAIA_B_P3B3_GPIO 1
// Codec control / status bits
`define UAIA_B_TXE 0
`define UAIA_B_RXF 1
// Codec address register direction bit
`define UAIA_B_DIR 7
// Misc source numbering in vector and misc mask
`define UAIA_M_CTX 0
`define UAIA_M_CRX 1
`define UAIA_M_DMA0 2
`define UAIA_M_DMA1 3
`define UAIA_M_EXTERNAL_IRQ_PIN 4
// Vector codes: 0x00-0x07 IN ep, 0x08-0x0f OUT ep, then these
`define UAIA_V_EP_OUT_BASE 8'h08
`define UAIA_V_USB_BASE 8'h10
`define UAIA_V_MISC_BASE 8'h18
`define UAIA_V_WIDTH 8
// Timing
`define UAIA_CLK_HZ 25000000
`define UAIA_SUSPEND_US 5000
`define UAIA_FRAME_US 1000
`endif

// [core/uaia_top.v]
// Interrupt aggregation, status flags and codec secondary-port handshake
`include "uaia_defines.vh"

module uaia_top #(
  parameter N_EP = 8,
  parameter SUSPEND_CYC = (`UAIA_CLK_HZ / 1000000) * `UAIA_SUSPEND_US,
  parameter FRAME_CYC = (`UAIA_CLK_HZ / 1000000) * `UAIA_FRAME_US
) (
  input wire mclk,
  input wire rst_n,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  input wire [N_EP-1:0] ep_in_ack,
  input wire [N_EP-1:0] ep_in_iso,
  input wire [N_EP-1:0] ep_out_done,
  input wire [N_EP-1:0] ep_out_iso,
  input wire usb_bus_reset,
  input wire usb_bus_idle,
  input wire sof_rcvd,
  input wire setup_ok,
  input wire dma0_done,
  input wire dma1_done,
  input wire external_irq_pin_n,
  input wire core_irq_b_src,
  input wire codec_frame,
  input wire codec_tx_taken,
  input wire codec_rx_valid,
  input wire [15:0] codec_rx_data,
  output reg codec_tx_req_q,
  output reg codec_rx_req_q,
  output reg [7:0] codec_slot_addr_q,
  output reg [15:0] codec_slot_data_q,
  output reg port3_bit2_q,
  output reg port3_bit3_q,
  output reg usb_logic_reset_q,
  output reg global_reset_q,
  output reg reset_output_pin_q
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  reg [1:0] rst_sync_q;
  wire rst_i_n = rst_sync_q[1];

  // Two stages so release never lands near an edge
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg [6:0] usb_status_reg_q;
  reg [1:0] usb_control_reg_q;
  reg [N_EP-1:0] ep_in_pend_q;
  reg [N_EP-1:0] ep_out_pend_q;
  reg [N_EP-1:0] ep_in_mask_q;
  reg [N_EP-1:0] ep_out_mask_q;
  reg [6:0] usb_mask_q;
  reg [4:0] misc_mask_q;
  reg [4:0] misc_pend_q;
  reg [1:0] codec_port_ctrl_status_q;
  reg [7:0] codec_secondary_addr_reg_q;
  reg [7:0] codec_secondary_data_low_q;
  reg [7:0] codec_secondary_data_high_q;
  reg [2:0] sof_miss_pend_q;
  reg suspended_q;
  reg [31:0] idle_cnt_q;
  reg [31:0] frame_cnt_q;
  reg [2:0] external_irq_pin_sync_q;
  reg rd_phase_q;

  wire vec_wr = reg_wr && (reg_addr == `UAIA_A_VECTOR);
  wire [7:0] vec = reg_wdata;

  // Clear pulses decoded from the vector write
  wire [N_EP-1:0] clr_in;
  wire [N_EP-1:0] clr_out;
  wire [6:0] clr_usb;
  wire [4:0] clr_misc;
  genvar gi;
  generate
    for (gi = 0; gi < N_EP; gi = gi + 1)
    begin : g_ep_clr
      assign clr_in[gi] = vec_wr && (vec == gi);
      assign clr_out[gi] = vec_wr && (vec == `UAIA_V_EP_OUT_BASE + gi);
    end
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_usb_clr
      assign clr_usb[gi] = vec_wr && (vec == `UAIA_V_USB_BASE + gi);
    end
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_misc_clr
      assign clr_misc[gi] = vec_wr && (vec == `UAIA_V_MISC_BASE + gi);
    end
  endgenerate

  // ****************************************************************
  // External pin synchroniser and fall detect
  // ****************************************************************
  // Stage 0 feeds stage 1 only; the edge is taken from stages 1 and 2
  always @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
      external_irq_pin_sync_q <= 3'b111;
    else
      external_irq_pin_sync_q <= {external_irq_pin_sync_q[1:0], external_irq_pin_n};
  end
  wire external_irq_pin_fall = external_irq_pin_sync_q[2] && !external_irq_pin_sync_q[1];

  // ****************************************************************
  // Endpoint pending bits
  // ****************************************************************
  // Set beats clear when both arrive together
  always @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      ep_in_pend_q <= {N_EP{1'b0}};
      ep_out_pend_q <= {N_EP{1'b0}};
    end
    else if (usb_status_reg_q[`UAIA_B_RST])
    begin
      ep_in_pend_q <= {N_EP{1'b0}};
      ep_out_pend_q <= {N_EP{1'b0}};
    end
    else
    begin
      ep_in_pend_q <= (ep_in_pend_q & ~clr_in) | (ep_in_ack & ~ep_in_iso);
      ep_out_pend_q <= (ep_out_pend_q & ~clr_out) |
                       (ep_out_done & ~ep_out_iso);
    end
  end

  // ****************************************************************
  // Suspend, frame timers
  // ****************************************************************
  // Idle counter saturates so one long idle gives one suspend event
  wire sus_hit = usb_bus_idle && (idle_cnt_q == SUSPEND_CYC);
  wire pseudo_frame_flag_hit = !sof_rcvd && (frame_cnt_q == FRAME_CYC);
  always @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      idle_cnt_q <= 32'h0000_0000;
      frame_cnt_q <= 32'h0000_0000;
      suspended_q <= 1'b0;
    end
    else if (usb_status_reg_q[`UAIA_B_RST])
    begin
      // Bus reset is USB logic reset: timers restart afterwards
      idle_cnt_q <= 32'h0000_0000;
      frame_cnt_q <= 32'h0000_0000;
      suspended_q <= 1'b0;
    end
    else
    begin
      if (!usb_bus_idle)
        idle_cnt_q <= 32'h0000_0000;
      else if (idle_cnt_q <= SUSPEND_CYC)
        idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
      // Restarts after a pseudo frame to keep a 1 ms cadence
      if (sof_rcvd || pseudo_frame_flag_hit)
        frame_cnt_q <= 32'h0000_0000;
      else
        frame_cnt_q <= frame_cnt_q + 32'h0000_0001;
      if (sus_hit)
        suspended_q <= 1'b1;
      else if (!usb_bus_idle)
        suspended_q <= 1'b0;
    end
  end
  wire res_hit = suspended_q && !usb_bus_idle;

  // ****************************************************************
  // USB status flags
  // ****************************************************************
  reg [6:0] usb_set;
  always @*
  begin
    usb_set = 7'h00;
    usb_set[`UAIA_B_RST] = usb_bus_reset;
    usb_set[`UAIA_B_SUS] = sus_hit;
    usb_set[`UAIA_B_RES] = res_hit;
    usb_set[`UAIA_B_SOF] = sof_rcvd;
    usb_set[`UAIA_B_PSEUDO_FRAME_FLAG] = pseudo_frame_flag_hit;
    // Second setup while flag held goes to overwrite only
    usb_set[`UAIA_B_SETUP] = setup_ok && !usb_status_reg_q[`UAIA_B_SETUP];
    usb_set[`UAIA_B_SETUP_OVERWRITE_FLAG] = setup_ok && usb_status_reg_q[`UAIA_B_SETUP];
  end

  // Global reset wipes the whole status register, flag included
  always @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
      usb_status_reg_q <= 7'h00;
    else if (global_reset_q)
      usb_status_reg_q <= 7'h00;
    else
      usb_status_reg_q <= (usb_status_reg_q & ~clr_usb) | usb_set;
  end

  // ****************************************************************
  // Reset outputs
  // ****************************************************************
  always @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      usb_logic_reset_q <= 1'b0;
      global_reset_q <= 1'b0;
      reset_output_pin_q <= 1'b0;
    end
    else
    begin
      usb_logic_reset_q <= usb_status_reg_q[`UAIA_B_RST];
      global_reset_q <= usb_status_reg_q[`UAIA_B_RST] &&
                        usb_control_reg_q[`UAIA_B_FRST_EN];
      reset_output_pin_q <= usb_status_reg_q[`UAIA_B_RST] &&
                            usb_control_reg_q[`UAIA_B_FRST_EN];
    end
  end

  // ****************************************************************
  // Misc pending: codec, DMA, external pin
  // ****************************************************************
  wire [4:0] misc_set = {external_irq_pin_fall, dma1_done, dma0_done,
                         codec_rx_valid && rd_phase_q,
                         codec_tx_req_q && codec_tx_taken};
  always @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
      misc_pend_q <= 5'h00;
    else
      misc_pend_q <= (misc_pend_q & ~clr_misc) | misc_set;
  end

  // ****************************************************************
  // Codec secondary port
  // ****************************************************************
  wire addr_wr = reg_wr && (reg_addr == `UAIA_A_CODEC_ADDR);
  wire datl_rd = reg_rd && (reg_addr == `UAIA_A_CODEC_DATL);
  always @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      codec_port_ctrl_status_q <= 2'b01;
      codec_secondary_addr_reg_q <= 8'h00;
      codec_secondary_data_low_q <= 8'h00;
      codec_secondary_data_high_q <= 8'h00;
      codec_tx_req_q <= 1'b0;
      codec_rx_req_q <= 1'b0;
      codec_slot_addr_q <= 8'h00;
      codec_slot_data_q <= 16'h0000;
      rd_phase_q <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == `UAIA_A_CODEC_DATL)
        codec_secondary_data_low_q <= reg_wdata;
      else if (codec_rx_valid && rd_phase_q)
        codec_secondary_data_low_q <= codec_rx_data[7:0];
      if (reg_wr && reg_addr == `UAIA_A_CODEC_DATH)
        codec_secondary_data_high_q <= reg_wdata;
      else if (codec_rx_valid && rd_phase_q)
        codec_secondary_data_high_q <= codec_rx_data[15:8];
      if (addr_wr)
        codec_secondary_addr_reg_q <= reg_wdata;
      // Transmit-empty: cleared by an address write with DIR low, set on codec accept
      if (codec_tx_req_q && codec_tx_taken)
        codec_port_ctrl_status_q[`UAIA_B_TXE] <= 1'b1;
      else if (addr_wr && !reg_wdata[`UAIA_B_DIR])
        codec_port_ctrl_status_q[`UAIA_B_TXE] <= 1'b0;
      // Receive-full: new data wins over a same-cycle read
      if (codec_rx_valid && rd_phase_q)
        codec_port_ctrl_status_q[`UAIA_B_RXF] <= 1'b1;
      else if (datl_rd)
        codec_port_ctrl_status_q[`UAIA_B_RXF] <= 1'b0;
      // Request waits for next frame boundary; slot placed by port
      if (addr_wr)
      begin
        codec_slot_addr_q <= reg_wdata;
        codec_slot_data_q <= {codec_secondary_data_high_q,
                              codec_secondary_data_low_q};
      end
      if (addr_wr && !reg_wdata[`UAIA_B_DIR])
        codec_tx_req_q <= 1'b1;
      else if (codec_tx_taken)
        codec_tx_req_q <= 1'b0;
      if (addr_wr && reg_wdata[`UAIA_B_DIR])
        codec_rx_req_q <= 1'b1;
      else if (codec_frame && codec_rx_req_q)
        codec_rx_req_q <= 1'b0;
      // Data accepted only in the frame after the address went out
      if (codec_frame && codec_rx_req_q)
        rd_phase_q <= 1'b1;
      else if (codec_rx_valid)
        rd_phase_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Masks and control
  // ****************************************************************
  always @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      usb_control_reg_q <= 2'b00;
      ep_in_mask_q <= {N_EP{1'b0}};
      ep_out_mask_q <= {N_EP{1'b0}};
      usb_mask_q <= 7'h00;
      misc_mask_q <= 5'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `UAIA_A_USB_CONTROL)
        usb_control_reg_q <= reg_wdata[1:0];
      else if (reg_addr == `UAIA_A_EP_IN_MASK)
        ep_in_mask_q <= reg_wdata[N_EP-1:0];
      else if (reg_addr == `UAIA_A_EP_OUT_MASK)
        ep_out_mask_q <= reg_wdata[N_EP-1:0];
      else if (reg_addr == `UAIA_A_USB_MASK)
        usb_mask_q <= reg_wdata[6:0];
      else if (reg_addr == `UAIA_A_MISC_MASK)
        misc_mask_q <= reg_wdata[4:0];
    end
  end

  // ****************************************************************
  // Combined interrupt lines
  // ****************************************************************
  // Mask bit 1 enables; reset flag only interrupts when function reset is disabled
  wire [6:0] usb_irq_src = usb_status_reg_q &
    {6'h3f, ~usb_control_reg_q[`UAIA_B_FRST_EN]};
  wire any_irq = |(ep_in_pend_q & ep_in_mask_q) |
                 |(ep_out_pend_q & ep_out_mask_q) |
                 |(usb_irq_src & usb_mask_q) |
                 |(misc_pend_q & misc_mask_q);
  // Lines are active low into the core port
  always @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      port3_bit2_q <= 1'b1;
      port3_bit3_q <= 1'b1;
    end
    else
    begin
      port3_bit2_q <= ~any_irq;
      port3_bit3_q <= usb_control_reg_q[`UAIA_B_P3B3_GPIO] ? 1'b1 :
                      core_irq_b_src;
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  // Unmapped reads return zero; data valid one cycle after strobe
  always @(posedge mclk or negedge rst_i_n)
  begin
    if (!rst_i_n)
      reg_rdata_q <= 8'h00;
    else if (!reg_rd)
      reg_rdata_q <= 8'h00;
    else if (reg_addr == `UAIA_A_USB_STATUS)
      reg_rdata_q <= {1'b0, usb_status_reg_q};
    else if (reg_addr == `UAIA_A_USB_CONTROL)
      reg_rdata_q <= {6'h00, usb_control_reg_q};
    else if (reg_addr == `UAIA_A_EP_IN_STAT)
      reg_rdata_q <= ep_in_pend_q;
    else if (reg_addr == `UAIA_A_EP_OUT_STAT)
      reg_rdata_q <= ep_out_pend_q;
    else if (reg_addr == `UAIA_A_EP_IN_MASK)
      reg_rdata_q <= ep_in_mask_q;
    else if (reg_addr == `UAIA_A_EP_OUT_MASK)
      reg_rdata_q <= ep_out_mask_q;
    else if (reg_addr == `UAIA_A_USB_MASK)
      reg_rdata_q <= {1'b0, usb_mask_q};
    else if (reg_addr == `UAIA_A_CODEC_CTRL)
      reg_rdata_q <= {6'h00, codec_port_ctrl_status_q};
    else if (reg_addr == `UAIA_A_CODEC_ADDR)
      reg_rdata_q <= codec_secondary_addr_reg_q;
    else if (reg_addr == `UAIA_A_CODEC_DATL)
      reg_rdata_q <= codec_secondary_data_low_q;
    else if (reg_addr == `UAIA_A_CODEC_DATH)
      reg_rdata_q <= codec_secondary_data_high_q;
    else if (reg_addr == `UAIA_A_MISC_MASK)
      reg_rdata_q <= {3'h0, misc_mask_q};
    else if (reg_addr == `UAIA_A_PENDING)
      reg_rdata_q <= {3'h0, misc_pend_q};
    else
      reg_rdata_q <= 8'h00;
  end

endmodule // uaia_top

// [tb/uaia_mcu_model.sv]
// Firmware-side model: register port master of the aggregator
module uaia_mcu_model (
  input wire logic mclk,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Bus cycles
  // ****************************************
  // Idle bus from time zero
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write; the slave never stalls, so no wait loop
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata_q;
  endtask
  // Vector write drops one pending source and its flag
  task automatic clr(input logic [7:0] code);
    wr(4'h2, code);
  endtask
endmodule // uaia_mcu_model

// [tb/uaia_top_sva.sv]
// Port-level assertions for the interrupt aggregator
module uaia_top_sva #(
  parameter N_EP = 8
) (
  input wire mclk,
  input wire rst_n,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata_q,
  input wire [N_EP-1:0] ep_in_ack,
  input wire [N_EP-1:0] ep_in_iso,
  input wire sof_rcvd,
  input wire external_irq_pin_n,
  input wire codec_tx_taken,
  input wire codec_tx_req_q,
  input wire port3_bit2_q,
  input wire port3_bit3_q,
  input wire usb_logic_reset_q,
  input wire global_reset_q,
  input wire reset_output_pin_q
);
  // ****************************************
  // Shadow registers and checks
  // ****************************************
  logic [7:0] in_m_q, usb_m_q, misc_m_q, ctl_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Mirror of mask and control writes, so checks know what is enabled
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_m_q <= 8'h00;
      usb_m_q <= 8'h00;
      misc_m_q <= 8'h00;
      ctl_q <= 8'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 4'h5) in_m_q <= reg_wdata;
      if (reg_addr == 4'h7) usb_m_q <= reg_wdata;
      if (reg_addr == 4'hc) misc_m_q <= reg_wdata;
      if (reg_addr == 4'h1) ctl_q <= reg_wdata;
    end
  end
  sequence tx_start_s;
    reg_wr && reg_addr == 4'h9 && !reg_wdata[7];
  endsequence
  sequence ep_event_s;
    |(ep_in_ack & ~ep_in_iso & in_m_q[N_EP-1:0]);
  endsequence
  rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
    else $error("read data outside read cycle");
  rst_pin_a: assert property (global_reset_q == reset_output_pin_q)
    else $error("reset pin differs from global reset");
  usb_rst_a: assert property ($rose(global_reset_q)
    |-> usb_logic_reset_q)
    else $error("global reset without usb reset");
  ep_irq_a: assert property (ep_event_s |-> ##2 !port3_bit2_q)
    else $error("endpoint event did not interrupt");
  sof_irq_a: assert property (sof_rcvd && usb_m_q[3]
    |-> ##2 !port3_bit2_q)
    else $error("frame event did not interrupt");
  tx_start_a: assert property (tx_start_s |=> codec_tx_req_q)
    else $error("codec transmit not started");
  tx_done_a: assert property (codec_tx_taken && codec_tx_req_q
    |=> !codec_tx_req_q)
    else $error("codec transmit still pending");
  gpio_high_a: assert property (ctl_q[1] && $past(ctl_q[1], 2)
    |-> port3_bit3_q)
    else $error("second interrupt pin not released");
  pin_irq_a: assert property ($fell(external_irq_pin_n) && misc_m_q[4]
    |-> ##[1:6] !port3_bit2_q)
    else $error("external pin did not interrupt");
endmodule // uaia_top_sva
bind uaia_top uaia_top_sva #(.N_EP(N_EP)) u_sva (.mclk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .ep_in_ack, .ep_in_iso,
  .sof_rcvd, .external_irq_pin_n, .codec_tx_taken, .codec_tx_req_q,
  .port3_bit2_q, .port3_bit3_q, .usb_logic_reset_q, .global_reset_q,
  .reset_output_pin_q);

// [tb/uaia_top_bench.sv]
// Self-checking bench for the interrupt aggregator
module uaia_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Signals, helpers and main sequence
  // ****************************************
  localparam int SUS = 50;
  localparam int FRM = 40;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_q, ep_in_ack, ep_in_iso, ev, q;
  logic [7:0] ep_out_done, ep_out_iso, codec_slot_addr_q;
  logic reg_wr, reg_rd, usb_bus_idle, external_irq_pin_n, core_irq_b_src;
  logic codec_tx_req_q, codec_rx_req_q, port3_bit2_q, port3_bit3_q;
  logic usb_logic_reset_q, global_reset_q, reset_output_pin_q;
  logic [15:0] codec_rx_data, codec_slot_data_q;
  logic [31:0] seed = 32'he04e_7538;
  logic [31:0] r;
  int i, k, n_fail, checks_done;
  uaia_mcu_model u_mcu (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_q);
  uaia_top #(.SUSPEND_CYC(SUS), .FRAME_CYC(FRM)) u_dut (.mclk, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .ep_in_ack,
    .ep_in_iso, .ep_out_done, .ep_out_iso, .usb_bus_reset(ev[0]),
    .usb_bus_idle, .sof_rcvd(ev[1]), .setup_ok(ev[2]), .dma0_done(ev[3]),
    .dma1_done(ev[4]), .external_irq_pin_n, .core_irq_b_src,
    .codec_frame(ev[5]), .codec_tx_taken(ev[6]), .codec_rx_valid(ev[7]),
    .codec_rx_data, .codec_tx_req_q, .codec_rx_req_q, .codec_slot_addr_q,
    .codec_slot_data_q, .port3_bit2_q, .port3_bit3_q, .usb_logic_reset_q,
    .global_reset_q, .reset_output_pin_q);
  // 25 MHz clock
  always #20 mclk = ~mclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] bitv(input int n);
    return 8'h01 << n;
  endfunction
  // Isochronous endpoints never post a completion
  function automatic logic [7:0] ep_exp(input logic iso, input int n);
    return iso ? 8'h00 : bitv(n);
  endfunction
  task automatic conclude();
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Sample a little after the edge so updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_mcu.rd(a, d);
    cmp(d, e);
  endtask
  // Combined line is active low
  task automatic chk_irq(input logic e);
    cyc(3);
    cmp(port3_bit2_q, !e);
  endtask
  task automatic pulse(input int n);
    @(posedge mclk);
    ev[n] <= 1'b1;
    @(posedge mclk);
    ev[n] <= 1'b0;
  endtask
  task automatic ev_ep(input logic [3:0] n, input logic iso);
    @(posedge mclk);
    ep_in_iso <= {8{iso}};
    ep_out_iso <= {8{iso}};
    if (n[3]) ep_out_done <= bitv(n[2:0]);
    else ep_in_ack <= bitv(n[2:0]);
    @(posedge mclk);
    ep_out_done <= 8'h00;
    ep_in_ack <= 8'h00;
  endtask
  // Flag and line up, then vector clear and a zero USB mask drop the line
  task automatic usb_chk(input int b);
    logic [7:0] d;
    chk_irq(1'b1);
    u_mcu.rd(4'h0, d);
    cmp(d[b], 1'b1);
    u_mcu.clr(8'(8'h10 + b));
    u_mcu.wr(4'h7, 8'h00);
    chk_irq(1'b0);
  endtask
  initial
  begin
    {ep_in_ack, ep_in_iso, ep_out_done, ep_out_iso, ev} = '0;
    {usb_bus_idle, codec_rx_data} = '0;
    external_irq_pin_n = 1'b1;
    core_irq_b_src = 1'b1;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    cyc(3);
    cmp(port3_bit2_q, 1'b1);
    rdc(4'h0, 8'h00);
    rdc(4'h8, 8'h01);
    rdc(4'he, 8'h00);
    // Random endpoint completions, some isochronous
    u_mcu.wr(4'h5, 8'hff);
    u_mcu.wr(4'h6, 8'hff);
    repeat (16)
    begin
      r = rnd();
      ev_ep(r[3:0], r[4]);
      rdc(r[3] ? 4'h4 : 4'h3, ep_exp(r[4], r[2:0]));
      chk_irq(!r[4]);
      u_mcu.clr({4'h0, r[3:0]});
      chk_irq(1'b0);
    end
    u_mcu.wr(4'h5, 8'hfe);
    ev_ep(4'h0, 1'b0);
    chk_irq(1'b0);
    u_mcu.clr(8'h00);
    // Frame, setup pair, suspend and resume, missed frame
    u_mcu.wr(4'h7, bitv(3));
    pulse(1);
    usb_chk(3);
    u_mcu.wr(4'h7, 8'h60);
    pulse(2);
    pulse(2);
    u_mcu.rd(4'h0, q);
    cmp(q & 8'h60, 8'h60);
    u_mcu.clr(8'h16);
    usb_chk(5);
    u_mcu.wr(4'h7, 8'h06);
    @(posedge mclk);
    usb_bus_idle <= 1'b1;
    cyc(SUS + 8);
    u_mcu.rd(4'h0, q);
    cmp(q[2:1], 2'b01);
    @(posedge mclk);
    usb_bus_idle <= 1'b0;
    cyc(4);
    u_mcu.rd(4'h0, q);
    cmp(q[2:1], 2'b11);
    u_mcu.clr(8'h11);
    usb_chk(2);
    u_mcu.wr(4'h7, bitv(4));
    u_mcu.clr(8'h14);
    cyc(FRM + 5);
    usb_chk(4);
    u_mcu.wr(4'h7, bitv(0));
    pulse(0);
    cyc(2);
    cmp(usb_logic_reset_q, 1'b1);
    usb_chk(0);
    cmp(usb_logic_reset_q, 1'b0);
    // Codec secondary write then read
    u_mcu.wr(4'hc, 8'h03);
    r = rnd();
    u_mcu.wr(4'ha, r[7:0]);
    u_mcu.wr(4'hb, r[15:8]);
    u_mcu.wr(4'h9, {1'b0, r[22:16]});
    cyc(1);
    cmp(codec_tx_req_q, 1'b1);
    cmp(codec_slot_data_q, r[15:0]);
    cmp(codec_slot_addr_q, {1'b0, r[22:16]});
    rdc(4'h8, 8'h00);
    pulse(6);
    rdc(4'h8, 8'h01);
    chk_irq(1'b1);
    u_mcu.clr(8'h18);
    chk_irq(1'b0);
    rdc(4'h8, 8'h01);
    u_mcu.wr(4'h9, {1'b1, r[30:24]});
    cyc(1);
    cmp(codec_rx_req_q, 1'b1);
    cmp(codec_slot_addr_q, {1'b1, r[30:24]});
    // Data ahead of the address frame must be ignored
    pulse(7);
    r = rnd();
    codec_rx_data <= r[15:0];
    rdc(4'h8, 8'h01);
    pulse(5);
    cyc(1);
    cmp(codec_rx_req_q, 1'b0);
    pulse(7);
    rdc(4'h8, 8'h03);
    rdc(4'hb, r[15:8]);
    rdc(4'ha, r[7:0]);
    rdc(4'h8, 8'h01);
    chk_irq(1'b1);
    u_mcu.clr(8'h19);
    chk_irq(1'b0);
    // DMA channels and the external pin, held low past its clear
    for (i = 2; i < 5; i++)
    begin
      u_mcu.wr(4'hc, bitv(i));
      if (i < 4) pulse(i + 1);
      else external_irq_pin_n <= 1'b0;
      cyc(6);
      chk_irq(1'b1);
      u_mcu.clr(8'(8'h18 + i));
      chk_irq(1'b0);
    end
    r = rnd();
    @(posedge mclk);
    external_irq_pin_n <= 1'b1;
    core_irq_b_src <= r[0];
    cyc(4);
    cmp(port3_bit3_q, r[0]);
    @(posedge mclk);
    core_irq_b_src <= 1'b0;
    cyc(4);
    cmp(port3_bit3_q, 1'b0);
    u_mcu.wr(4'h1, 8'h02);
    cyc(4);
    cmp(port3_bit3_q, 1'b1);
    // Bus reset with function reset enabled
    u_mcu.wr(4'h1, 8'h01);
    pulse(0);
    k = 0;
    while (global_reset_q !== 1'b1 && k < 10)
    begin
      cyc(1);
      k++;
    end
    // A reset that never comes counts as a mismatch
    if (k == 10)
      n_fail++;
    else
    begin
      cmp(reset_output_pin_q, 1'b1);
      cyc(4);
      rdc(4'h0, 8'h00);
      chk_irq(1'b0);
    end
    conclude();
  end
endmodule // uaia_top_bench
